// ==== logic/scil_pkg.sv ====
package scil_pkg;
    localparam int NCH = 2;
    localparam int NSRC = 6;
    localparam int FIFO_DEPTH = 3;
    // Register addresses
    localparam logic [3:0] A_VEC = 4'h0;
    localparam logic [3:0] A_MIC = 4'h1;
    localparam logic [3:0] A_SVEC = 4'h2;
    localparam logic [3:0] A_PEND = 4'h3;
    localparam logic [1:0] O_MODE = 2'h0;
    localparam logic [1:0] O_CTRL = 2'h1;
    localparam logic [1:0] O_STAT = 2'h2;
    localparam logic [1:0] O_DATA = 2'h3;
    // Master control bits
    localparam int MIC_MIE = 0;
    localparam int MIC_VIS = 1;
    localparam int MIC_NV = 2;
    // Transfer mode bits
    localparam int M_EXT = 0;
    localparam int M_TX = 1;
    localparam int M_RXLO = 2;
    localparam int M_PAR = 4;
    localparam int M_WEN = 5;
    localparam int M_WFN = 6;
    localparam int M_WRX = 7;
    // Channel control bits
    localparam int C_ECHO = 0;
    localparam int C_LOOP = 1;
    localparam int C_TXEN = 2;
    localparam int C_RXEN = 3;
    localparam int C_AUTO = 4;
    // Command bits, three per channel
    localparam int CMD_EXT = 0;
    localparam int CMD_TX = 1;
    localparam int CMD_ERR = 2;
    localparam int CMD_W = 3;
    localparam int CMD_IUS = 6;
    // Status vector codes
    localparam logic [2:0] VS_TX = 3'h0;
    localparam logic [2:0] VS_EXT = 3'h1;
    localparam logic [2:0] VS_RX = 3'h2;
    localparam logic [2:0] VS_SPEC = 3'h3;
    localparam logic [2:0] VS_CHA = 3'h4;
    localparam int VS_LO = 1;
    localparam logic [7:0] VEC_RST = 8'h00;
    localparam logic [7:0] MIC_RST = 8'h00;

    typedef enum logic [1:0] {
        RXI_OFF = 2'h0,
        RXI_FIRST = 2'h1,
        RXI_ALL = 2'h3,
        RXI_SPEC = 2'h2
    } scil_rxi_t;

    typedef struct packed {
        logic rxd;
        logic tx_line;
        logic cts;
        logic dcd;
        logic ri;
        logic brk;
        logic underrun;
        logic baud_zero;
        logic rx_valid;
        logic rx_perr;
        logic [7:0] rx_data;
        logic tx_taken;
    } scil_chin_t;

    typedef struct packed {
        logic txd;
        logic rx_line;
        logic tx_en;
        logic rx_en;
        logic tx_valid;
        logic [7:0] tx_data;
        logic wreq_o;
        logic wreq_oe;
    } scil_chout_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [FIFO_DEPTH-1:0][8:0] fifo;
        logic [1:0] cnt;
        logic ovr;
        logic first_arm;
        logic first_ip;
        logic tx_full;
        logic tx_ip;
        logic ext_ip;
        logic cts_q;
        logic dcd_q;
        logic ri_q;
        logic brk_q;
        scil_chout_t out;
    } scil_ch_t;

    typedef struct packed {
        scil_ch_t [NCH-1:0] ch;
        logic [7:0] vec;
        logic [7:0] mic;
        logic [NSRC-1:0] in_service_flag;
        logic [7:0] rdata;
        logic irq_n;
        logic ceo;
    } scil_st_t;
endpackage

// ==== logic/scil_top.sv ====
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
// Function
// - Auto Echo routes serial input to output
// - Echo path is raw, never decoded
// - Echo ignores clear-to-send as enable
// - Loopback feeds transmit data to receiver
// - Loopback ignores modem enables, keeps interrupts
// - Status registers stay current for polling
// - Separate plain vector and status vector addresses
// - Six sources: pending, in-service, enable flags
// - Global enable clear blocks every request
// - No pending while disabled; one pending register
// - Request low on pending and chain in
// - In-service blocks lower sources and chain out
// - Acknowledge sets in-service without higher request
// - A over B; receive, transmit, external
// - Transmit interrupt on buffer becoming empty
// - Three receive interrupt modes
// - Special condition: overrun, optional parity error
// - Special condition possible after first character
// - External events: modem edges, underrun, zero, break
// - Wait signals not ready; request signals ready
// - Three-entry receive FIFO per channel
// - Vector and master control shared by channels
// - Acknowledge read returns vector unless no-vector bit set, sets in-service
module scil_top
    import scil_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // Interrupt chain
    input wire logic irq_acknowledge_n,
    input wire logic chain_enable_in,
    output logic chain_enable_out,
    output logic irq_req_n,
    // Channels, index 0 is channel A
    input wire scil_chin_t [NCH-1:0] ch_i,
    output scil_chout_t [NCH-1:0] ch_o
);
    scil_st_t s;
    scil_st_t n;
    logic [NSRC-1:0] ip;
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] spec;
    logic ack;
    logic [2:0] top_src;
    logic top_ok;
    logic [2:0] hi_src;
    logic hi_ok;

    function automatic logic [7:0] mod_vec(input logic [7:0] v,
        input logic ok, input logic [2:0] src, input logic sp);
        logic [2:0] code;
        code = VS_SPEC;
        if (ok)
        begin
            unique case (src % 3'h3)
                3'h0: code = sp ? VS_SPEC : VS_RX;
                3'h1: code = VS_TX;
                default: code = VS_EXT;
            endcase
            if (src < 3'h3)
                code = code | VS_CHA;
        end
        mod_vec = v;
        mod_vec[VS_LO+:3] = code;
    endfunction

    always_comb
    begin
        logic blk;
        logic chsel;
        logic [1:0] off;
        logic wr_mode;
        logic rd_data;
        logic wr_data;
        logic cmd;
        logic ev;
        logic rdy;
        logic push;
        scil_rxi_t rxm;
        blk = 1'b0;
        chsel = 1'b0;
        off = bus_addr[1:0];
        wr_mode = 1'b0;
        rd_data = 1'b0;
        wr_data = 1'b0;
        cmd = bus_wr && bus_addr == A_PEND;
        ev = 1'b0;
        rdy = 1'b0;
        push = 1'b0;
        rxm = RXI_OFF;
        n = s;
        n.rdata = 8'h00;
        top_src = 3'h0;
        top_ok = 1'b0;
        hi_src = 3'h0;
        hi_ok = 1'b0;
        // Pending flags from registered state
        for (int c = 0; c < NCH; c++)
        begin
            rxm = scil_rxi_t'(s.ch[c].mode[M_RXLO+:2]);
            spec[c*3] = s.ch[c].ovr || (s.ch[c].mode[M_PAR]
                && s.ch[c].cnt != 2'h0 && s.ch[c].fifo[0][8]);
            spec[c*3+1] = 1'b0;
            spec[c*3+2] = 1'b0;
            unique case (rxm)
                RXI_OFF: ip[c*3] = 1'b0;
                RXI_FIRST: ip[c*3] = s.ch[c].first_ip || spec[c*3];
                RXI_ALL: ip[c*3] = s.ch[c].cnt != 2'h0 || spec[c*3];
                RXI_SPEC: ip[c*3] = spec[c*3];
            endcase
            ip[c*3+1] = s.ch[c].tx_ip && s.ch[c].mode[M_TX];
            ip[c*3+2] = s.ch[c].ext_ip && s.ch[c].mode[M_EXT];
        end
        // Internal chain in priority order
        for (int i = 0; i < NSRC; i++)
        begin
            blk = blk || s.in_service_flag[i];
            req[i] = ip[i] && !blk && s.mic[MIC_MIE]
                && chain_enable_in;
            if (req[i] && !top_ok)
            begin
                top_ok = 1'b1;
                top_src = 3'(i);
            end
            if (ip[i] && !hi_ok)
            begin
                hi_ok = 1'b1;
                hi_src = 3'(i);
            end
        end
        ack = !irq_acknowledge_n && bus_rd && top_ok;
        n.irq_n = !(|req);
        n.ceo = chain_enable_in && !(|s.in_service_flag) && !(!irq_acknowledge_n
            && s.mic[MIC_MIE] && |ip);
        // Shared registers
        if (bus_wr && bus_addr == A_VEC)
            n.vec = bus_wdata;
        if (bus_wr && bus_addr == A_MIC)
            n.mic = bus_wdata;
        if (cmd && bus_wdata[CMD_IUS])
        begin
            for (int i = NSRC - 1; i >= 0; i--)
                if (s.in_service_flag[i])
                    blk = 1'b0;
            for (int i = 0; i < NSRC; i++)
                if (s.in_service_flag[i] && !blk)
                begin
                    n.in_service_flag[i] = 1'b0;
                    blk = 1'b1;
                end
        end
        if (ack)
        begin
            n.in_service_flag[top_src] = 1'b1;
            if (!s.mic[MIC_NV])
                n.rdata = s.mic[MIC_VIS] ? mod_vec(s.vec, 1'b1, top_src,
                    spec[top_src]) : s.vec;
        end
        else if (bus_rd && irq_acknowledge_n)
        begin
            unique case (bus_addr)
                A_VEC: n.rdata = s.vec;
                A_SVEC: n.rdata = mod_vec(s.vec, hi_ok, hi_src,
                    spec[hi_src]);
                A_PEND: n.rdata = {2'h0, ip[0], ip[1], ip[2], ip[3],
                    ip[4], ip[5]};
                default: n.rdata = 8'h00;
            endcase
        end
        // Per-channel logic
        for (int c = 0; c < NCH; c++)
        begin
            chsel = bus_addr[3:2] == 2'(c + 1);
            wr_mode = bus_wr && chsel && off == O_MODE;
            wr_data = bus_wr && chsel && off == O_DATA;
            rd_data = bus_rd && irq_acknowledge_n && chsel
                && off == O_DATA;
            if (wr_mode)
            begin
                n.ch[c].mode = bus_wdata;
                n.ch[c].first_arm = bus_wdata[M_RXLO+:2] == RXI_FIRST;
            end
            if (bus_wr && chsel && off == O_CTRL)
                n.ch[c].ctrl = bus_wdata;
            if (bus_rd && irq_acknowledge_n && chsel && !ack)
            begin
                unique case (off)
                    O_MODE: n.rdata = 8'h00;
                    O_CTRL: n.rdata = s.ch[c].ctrl;
                    O_STAT: n.rdata = {s.ch[c].brk_q, s.ch[c].cts_q,
                        s.ch[c].ri_q, s.ch[c].dcd_q, !s.ch[c].tx_full,
                        1'b0, s.ch[c].ovr, s.ch[c].cnt != 2'h0};
                    O_DATA: n.rdata = s.ch[c].fifo[0][7:0];
                endcase
            end
            // Serial routing
            n.ch[c].out.txd = (s.ch[c].ctrl[C_ECHO]
                || s.ch[c].ctrl[C_LOOP]) ? ch_i[c].rxd
                : ch_i[c].tx_line;
            n.ch[c].out.rx_line = s.ch[c].ctrl[C_LOOP] ? ch_i[c].tx_line
                : ch_i[c].rxd;
            n.ch[c].out.tx_en = s.ch[c].ctrl[C_TXEN]
                && (!s.ch[c].ctrl[C_AUTO] || s.ch[c].ctrl[C_ECHO]
                || s.ch[c].ctrl[C_LOOP] || ch_i[c].cts);
            n.ch[c].out.rx_en = s.ch[c].ctrl[C_RXEN]
                && (!s.ch[c].ctrl[C_AUTO] || s.ch[c].ctrl[C_LOOP]
                || ch_i[c].dcd);
            // External/status events
            n.ch[c].cts_q = ch_i[c].cts;
            n.ch[c].dcd_q = ch_i[c].dcd;
            n.ch[c].ri_q = ch_i[c].ri;
            n.ch[c].brk_q = ch_i[c].brk;
            ev = (ch_i[c].cts != s.ch[c].cts_q)
                || (ch_i[c].dcd != s.ch[c].dcd_q)
                || (ch_i[c].ri != s.ch[c].ri_q)
                || (ch_i[c].brk != s.ch[c].brk_q)
                || ch_i[c].underrun || ch_i[c].baud_zero;
            if (cmd && bus_wdata[c*CMD_W+CMD_EXT])
                n.ch[c].ext_ip = 1'b0;
            if (ev && n.ch[c].mode[M_EXT])
                n.ch[c].ext_ip = 1'b1;
            // Transmit buffer
            if (ch_i[c].tx_taken && s.ch[c].tx_full)
                n.ch[c].tx_full = 1'b0;
            if (wr_data || (cmd && bus_wdata[c*CMD_W+CMD_TX]))
                n.ch[c].tx_ip = 1'b0;
            if (wr_data)
            begin
                n.ch[c].tx_full = 1'b1;
                n.ch[c].out.tx_data = bus_wdata;
            end
            if (ch_i[c].tx_taken && s.ch[c].tx_full
                && n.ch[c].mode[M_TX])
                n.ch[c].tx_ip = 1'b1;
            n.ch[c].out.tx_valid = n.ch[c].tx_full;
            // Receive FIFO
            if (rd_data && s.ch[c].cnt != 2'h0)
            begin
                for (int k = 0; k < FIFO_DEPTH - 1; k++)
                    n.ch[c].fifo[k] = s.ch[c].fifo[k+1];
                n.ch[c].cnt = s.ch[c].cnt - 2'h1;
                n.ch[c].first_ip = 1'b0;
            end
            if (cmd && bus_wdata[c*CMD_W+CMD_ERR])
                n.ch[c].ovr = 1'b0;
            push = ch_i[c].rx_valid && s.ch[c].ctrl[C_RXEN];
            if (push && n.ch[c].cnt == 2'(FIFO_DEPTH))
                n.ch[c].ovr = 1'b1;
            else if (push)
            begin
                n.ch[c].fifo[n.ch[c].cnt] = {ch_i[c].rx_perr,
                    ch_i[c].rx_data};
                n.ch[c].cnt = n.ch[c].cnt + 2'h1;
                if (s.ch[c].first_arm && !wr_mode)
                begin
                    n.ch[c].first_arm = 1'b0;
                    n.ch[c].first_ip = 1'b1;
                end
            end
            // Wait or request
            rdy = n.ch[c].mode[M_WRX] ? n.ch[c].cnt != 2'h0
                : !n.ch[c].tx_full;
            if (!n.ch[c].mode[M_WEN])
            begin
                n.ch[c].out.wreq_o = 1'b1;
                n.ch[c].out.wreq_oe = n.ch[c].mode[M_WFN];
            end
            else if (n.ch[c].mode[M_WFN])
            begin
                n.ch[c].out.wreq_o = !rdy;
                n.ch[c].out.wreq_oe = 1'b1;
            end
            else
            begin
                n.ch[c].out.wreq_o = 1'b0;
                n.ch[c].out.wreq_oe = !rdy;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.vec <= VEC_RST;
            s.mic <= MIC_RST;
            s.irq_n <= 1'b1;
            s.ch[0].out.wreq_o <= 1'b1;
            s.ch[1].out.wreq_o <= 1'b1;
        end
        else
            s <= n;
    end

    assign bus_rdata = s.rdata;
    assign irq_req_n = s.irq_n;
    assign chain_enable_out = s.ceo;
    assign ch_o[0] = s.ch[0].out;
    assign ch_o[1] = s.ch[1].out;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_mie_blocks_irq: assert property (!s.mic[MIC_MIE] |=> irq_req_n)
        else $error("request with global enable clear");
    a_chain_in_low: assert property (!chain_enable_in |=>
        irq_req_n && !chain_enable_out)
        else $error("activity with chain enable low");
    a_ius_blocks_out: assert property (|s.in_service_flag |=> !chain_enable_out)
        else $error("chain out high while in service");
    a_echo_route: assert property (s.ch[0].ctrl[C_ECHO] |=>
        ch_o[0].txd == $past(ch_i[0].rxd))
        else $error("echo path broken");
    a_loop_route: assert property (s.ch[0].ctrl[C_LOOP] |=>
        ch_o[0].rx_line == $past(ch_i[0].tx_line))
        else $error("loopback path broken");
    a_echo_cts_ignored: assert property (s.ch[0].ctrl[C_ECHO]
        && s.ch[0].ctrl[C_TXEN] |=> ch_o[0].tx_en)
        else $error("clear-to-send gated echo");
    a_ack_sets_ius: assert property (ack && s.in_service_flag == '0 |=>
        $countones(s.in_service_flag) == 1 && !chain_enable_out)
        else $error("acknowledge did not set one flag");
    a_fifo_bound: assert property (s.ch[0].cnt <= 2'(FIFO_DEPTH))
        else $error("receive fifo over depth");
    a_ext_edge: assert property (s.ch[0].mode[M_EXT]
        && ch_i[0].cts != s.ch[0].cts_q |=> s.ch[0].ext_ip)
        else $error("modem edge lost");
    a_tx_empty_irq: assert property (s.ch[1].tx_full
        && ch_i[1].tx_taken && s.ch[1].mode[M_TX] |=>
        s.ch[1].tx_ip)
        else $error("transmit empty not flagged");
    a_plain_vector: assert property (bus_rd && irq_acknowledge_n
        && bus_addr == A_VEC |=> bus_rdata == $past(s.vec))
        else $error("plain vector modified");
    a_req_rx_ready: assert property (s.ch[0].mode[M_WEN]
        && s.ch[0].mode[M_WFN] && s.ch[0].mode[M_WRX]
        |-> ch_o[0].wreq_o == (s.ch[0].cnt == 2'h0))
        else $error("request pin disagrees with fifo");
    a_wait_tx_busy: assert property (s.ch[0].mode[M_WEN]
        && !s.ch[0].mode[M_WFN] && !s.ch[0].mode[M_WRX]
        |-> ch_o[0].wreq_oe == s.ch[0].tx_full && !ch_o[0].wreq_o)
        else $error("wait pin disagrees with buffer");
    a_irq_needs_gate: assert property (!irq_req_n |->
        $past(chain_enable_in) && $past(s.mic[MIC_MIE]))
        else $error("request without chain or global enable");
    a_loop_rx_en: assert property (s.ch[0].ctrl[C_LOOP]
        && s.ch[0].ctrl[C_RXEN] |=> ch_o[0].rx_en)
        else $error("carrier detect gated loopback");
    a_ceo_needs_in: assert property (chain_enable_out |->
        $past(chain_enable_in) && $past(s.in_service_flag) == '0)
        else $error("chain out high while blocked");
    a_chan_a_first: assert property (!irq_acknowledge_n && bus_rd
        && ip[0] && s.in_service_flag == '0 && chain_enable_in && s.mic[MIC_MIE]
        |=> s.in_service_flag[0])
        else $error("channel A receive not served first");

    c_ext_irq: cover property (s.ch[0].ext_ip && !irq_req_n);
    c_ack: cover property (ack ##1 !chain_enable_out);
    c_fifo_full: cover property (s.ch[0].cnt == 2'(FIFO_DEPTH));
    c_overrun: cover property (s.ch[1].ovr);
    c_loop_on: cover property (s.ch[0].ctrl[C_LOOP] && ch_i[0].tx_line);
endmodule

// ==== testbench/scil_host.sv ====
`timescale 1ns/100ps
module scil_host
    import scil_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [3:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [7:0] bus_rdata,
    // Acknowledge
    output logic irq_acknowledge_n
);
    initial
    begin
        bus_addr = 4'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        irq_acknowledge_n = 1'b1;
    end

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        v = bus_rdata;
    endtask

    // Acknowledge held low around the read, chain settles first
    task automatic ack(output logic [7:0] v);
        @(posedge clk);
        irq_acknowledge_n <= 1'b0;
        @(posedge clk);
        rd(A_SVEC, v);
        @(posedge clk);
        irq_acknowledge_n <= 1'b1;
    endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
    import scil_pkg::*;
    localparam logic [3:0] AM = 4'h4, AC = 4'h5, AS = 4'h6, AD = 4'h7;
    localparam logic [3:0] BM = 4'h8, BC = 4'h9, BD = 4'hB;
    localparam logic [7:0] VEC = 8'hA5;
    logic clk, resetn, chain_enable_in, chain_enable_out, irq_req_n;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, d;
    logic bus_wr, bus_rd, irq_acknowledge_n;
    scil_chin_t [NCH-1:0] ch_i;
    scil_chout_t [NCH-1:0] ch_o;
    int bad_count, samples_checked, cycles;

    scil_top dut_u (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .irq_acknowledge_n(irq_acknowledge_n),
        .chain_enable_in(chain_enable_in),
        .chain_enable_out(chain_enable_out), .irq_req_n(irq_req_n),
        .ch_i(ch_i), .ch_o(ch_o));
    scil_host host_u (.clk(clk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .irq_acknowledge_n(irq_acknowledge_n));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask

    // Bounded wait for the request line
    task automatic wait_irq(input logic e);
        #1;
        for (int i = 0; i < 12 && irq_req_n !== e; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk({7'h00, irq_req_n}, {7'h00, e});
    endtask

    task automatic push(input logic [7:0] v);
        @(posedge clk);
        ch_i[0].rx_data <= v;
        ch_i[0].rx_valid <= 1'b1;
        @(posedge clk);
        ch_i[0].rx_valid <= 1'b0;
    endtask

    task automatic t_reset();
        chk({7'h00, irq_req_n}, 8'h01);
        chk({7'h00, chain_enable_out}, 8'h01);
        chk({7'h00, ch_o[0].wreq_oe}, 8'h00);
        host_u.wr(A_VEC, VEC);
        host_u.rd(A_VEC, d);
        chk(d, VEC);
        host_u.rd(4'hC, d);
        chk(d, 8'h00);
        host_u.rd(A_SVEC, d);
        chk(d, {VEC[7:4], 3'h3, VEC[0]});
    endtask

    task automatic t_irq();
        host_u.wr(A_MIC, 8'h03);
        host_u.wr(AM, 8'h0C);
        host_u.wr(AC, 8'h08);
        host_u.wr(BM, 8'h02);
        host_u.wr(BC, 8'h04);
        host_u.wr(BD, 8'h5A);
        repeat (4) @(posedge clk);
        #1;
        chk(ch_o[1].tx_data, 8'h5A);
        chk({7'h00, irq_req_n}, 8'h01);
        @(posedge clk);
        ch_i[1].tx_taken <= 1'b1;
        @(posedge clk);
        ch_i[1].tx_taken <= 1'b0;
        push(8'h3C);
        wait_irq(1'b0);
        host_u.rd(A_PEND, d);
        chk(d, 8'h22);
        host_u.rd(A_SVEC, d);
        chk(d, {VEC[7:4], VS_CHA | VS_RX, VEC[0]});
        host_u.ack(d);
        chk(d, {VEC[7:4], VS_CHA | VS_RX, VEC[0]});
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, irq_req_n}, 8'h01);
        chk({7'h00, chain_enable_out}, 8'h00);
        host_u.rd(AD, d);
        chk(d, 8'h3C);
        host_u.wr(A_PEND, 8'h40);
        wait_irq(1'b0);
        host_u.rd(A_SVEC, d);
        chk(d, {VEC[7:4], VS_TX, VEC[0]});
        host_u.wr(A_PEND, 8'h10);
        host_u.wr(BM, 8'h00);
        wait_irq(1'b1);
    endtask

    task automatic t_gate();
        host_u.wr(A_MIC, 8'h00);
        push(8'h11);
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, irq_req_n}, 8'h01);
        host_u.wr(A_MIC, 8'h03);
        wait_irq(1'b0);
        @(posedge clk);
        chain_enable_in <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, irq_req_n}, 8'h01);
        chk({7'h00, chain_enable_out}, 8'h00);
        @(posedge clk);
        chain_enable_in <= 1'b1;
        host_u.rd(AD, d);
        chk(d, 8'h11);
        wait_irq(1'b1);
    endtask

    task automatic t_fifo();
        host_u.wr(AM, 8'h00);
        for (int i = 1; i < 5; i++)
            push(8'(i));
        host_u.rd(AS, d);
        chk(d & 8'h03, 8'h03);
        for (int i = 1; i < 4; i++)
        begin
            host_u.rd(AD, d);
            chk(d, 8'(i));
        end
        host_u.rd(AS, d);
        chk(d & 8'h01, 8'h00);
        host_u.wr(A_PEND, 8'h04);
    endtask

    task automatic t_first();
        host_u.wr(AM, 8'h04);
        push(8'h21);
        push(8'h22);
        wait_irq(1'b0);
        host_u.rd(AD, d);
        chk(d, 8'h21);
        wait_irq(1'b1);
        for (int i = 0; i < 3; i++)
            push(8'h23);
        wait_irq(1'b0);
        host_u.rd(A_SVEC, d);
        chk(d, {VEC[7:4], VS_CHA | VS_SPEC, VEC[0]});
        host_u.rd(AD, d);
        chk(d, 8'h22);
        host_u.rd(AD, d);
        host_u.rd(AD, d);
        chk(d, 8'h23);
        host_u.wr(AM, 8'h08);
        wait_irq(1'b0);
        host_u.wr(A_PEND, 8'h04);
        wait_irq(1'b1);
        host_u.wr(AM, 8'h00);
    endtask

    task automatic t_dma();
        host_u.wr(AM, 8'hE0);
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, ch_o[0].wreq_oe, ch_o[0].wreq_o}, 8'h03);
        push(8'h77);
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, ch_o[0].wreq_oe, ch_o[0].wreq_o}, 8'h02);
        host_u.rd(AD, d);
        chk(d, 8'h77);
        host_u.wr(AM, 8'h20);
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, ch_o[0].wreq_oe, ch_o[0].wreq_o}, 8'h00);
        host_u.wr(AD, 8'h42);
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, ch_o[0].wreq_oe, ch_o[0].wreq_o}, 8'h02);
        chk({7'h00, ch_o[0].tx_valid}, 8'h01);
        chk(ch_o[0].tx_data, 8'h42);
        @(posedge clk);
        ch_i[0].tx_taken <= 1'b1;
        @(posedge clk);
        ch_i[0].tx_taken <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({6'h00, ch_o[0].wreq_oe, ch_o[0].wreq_o}, 8'h00);
        host_u.wr(AM, 8'h00);
    endtask

    task automatic t_ext();
        host_u.wr(AM, 8'h01);
        @(posedge clk);
        ch_i[0].cts <= 1'b1;
        wait_irq(1'b0);
        host_u.rd(A_SVEC, d);
        chk(d, {VEC[7:4], VS_CHA | VS_EXT, VEC[0]});
        host_u.rd(AS, d);
        chk(d & 8'h40, 8'h40);
        host_u.wr(A_PEND, 8'h01);
        wait_irq(1'b1);
        @(posedge clk);
        ch_i[0].cts <= 1'b0;
        wait_irq(1'b0);
        host_u.wr(A_PEND, 8'h01);
        host_u.wr(AM, 8'h00);
        wait_irq(1'b1);
    endtask

    task automatic t_route();
        host_u.wr(AC, 8'h15);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            ch_i[0].rxd <= i[0];
            repeat (2) @(posedge clk);
            #1;
            chk({7'h00, ch_o[0].txd}, {7'h00, i[0]});
        end
        chk({7'h00, ch_o[0].tx_en}, 8'h01);
        host_u.wr(AC, 8'h1A);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            ch_i[0].tx_line <= i[0];
            ch_i[0].rxd <= ~i[0];
            repeat (2) @(posedge clk);
            #1;
            chk({7'h00, ch_o[0].rx_line}, {7'h00, i[0]});
            chk({7'h00, ch_o[0].txd}, {7'h00, ~i[0]});
        end
        chk({7'h00, ch_o[0].rx_en}, 8'h01);
    endtask

    initial
    begin
        resetn = 1'b0;
        chain_enable_in = 1'b1;
        ch_i = '0;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_reset();
        t_irq();
        t_gate();
        t_fifo();
        t_first();
        t_dma();
        t_ext();
        t_route();
        finish_test();
    end
endmodule
